// ### design/dpiac_arbiter_config.sv
/*
 * Two-port bus arbiter with the shared non-volatile configuration register.
 * Assumes open-drain pins resolved outside; link_clk_i samples the pins,
 * core_clk_i runs the one-second release timer.
 */
// What this block does
// R1: Both clocks high and idle: arbiter inactive, both clock lines released.
// R2: START on one port drives the other port's clock line low.
// R3: Initiating clock high for one second releases the held clock line.
// R4: Register: bit3 write permit, bit2 pick high, bit1 pick low, bit0 single.
// R5: Single-bank flag set selects lower bank regardless of anything else.
// R6: Two banks, pick high 0: bank follows the bank-select pin.
// R7: Two banks, pick high 1: bank follows pick low, pin ignored.
// R8: Write permit bit gates only monitor-port memory writes.
// R9: Display-port writes are always permitted.
// R10: Configuration register keeps its value across resets.
// R11: Both ports reach the register: write address 62h, read 63h.
// R12: Read: START, 63h, ack, one data byte, master no-ack, STOP.
// R13: Write: START, 62h, dummy byte, value; each acked; STOP.
// R14: Release timer restarts when clock goes low, counts while high.
`timescale 1ns/100ps

module dpiac_arbiter_config
	import dpiac_pkg::*;
#(
	parameter int unsigned RELEASE_CYCLES = RELEASE_CYC
)
(
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic link_clk_i,
	input  wire logic monitor_port_clock_i,
	input  wire logic monitor_port_data_i,
	input  wire logic display_port_clock_i,
	input  wire logic display_port_data_i,
	input  wire logic bank_select_pin_i,
	output logic      monitor_port_clock_oe_n_o,
	output logic      display_port_clock_oe_n_o,
	output logic      monitor_port_data_oe_n_o,
	output logic      display_port_data_oe_n_o,
	output logic      upper_bank_active_o,
	output logic      single_bank_o,
	output logic      monitor_write_permit_o,
	output logic      display_write_permit_o,
	output logic      arb_busy_o
);

	////////////////////////////////////////////////////////////////////////
	// Link-domain reset release and pin synchronisers.

	logic                 link_rst_s1;
	logic                 link_rstn;
	logic [PORT_CNT-1:0]  scl_in;
	logic [PORT_CNT-1:0]  sda_in;
	logic [PORT_CNT-1:0]  scl_f;
	logic [PORT_CNT-1:0]  sda_f;
	logic                 bank_pin_f;

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			link_rst_s1 <= 1'b0;
			link_rstn   <= 1'b0;
		end
		else
		begin
			link_rst_s1 <= 1'b1;
			link_rstn   <= link_rst_s1;
		end
	end

	assign scl_in = {display_port_clock_i, monitor_port_clock_i};
	assign sda_in = {display_port_data_i, monitor_port_data_i};

	dpiac_sync #(.INIT(1'b0)) u_sync_bank
	(
		.clk_i  (link_clk_i),
		.rstn_i (link_rstn),
		.d_i    (bank_select_pin_i),
		.q_o    (bank_pin_f)
	);

	////////////////////////////////////////////////////////////////////////
	// Per-port bus slave for the configuration register (link domain).

	logic [7:0]           cfg = CFG_ERASED;
	logic [PORT_CNT-1:0]  sda_drv;
	logic [PORT_CNT-1:0]  start_tg;
	logic [PORT_CNT-1:0]  cfg_wr;
	logic [7:0]           cfg_wd [PORT_CNT];

	genvar p;
	generate
		for (p = 0; p < PORT_CNT; p++)
		begin : g_port
			dpiac_slv_st_t st;
			logic          scl_q;
			logic          sda_q;
			logic [7:0]    sh;
			logic [3:0]    cnt;
			logic          drv;
			logic          tg;
			logic          wr;
			logic          start_c;
			logic          stop_c;
			logic          rise;
			logic          fall;

			dpiac_sync #(.INIT(1'b1)) u_sync_scl
			(
				.clk_i  (link_clk_i),
				.rstn_i (link_rstn),
				.d_i    (scl_in[p]),
				.q_o    (scl_f[p])
			);

			dpiac_sync #(.INIT(1'b1)) u_sync_sda
			(
				.clk_i  (link_clk_i),
				.rstn_i (link_rstn),
				.d_i    (sda_in[p]),
				.q_o    (sda_f[p])
			);

			assign start_c = scl_q && scl_f[p] && sda_q && !sda_f[p];
			assign stop_c  = scl_q && scl_f[p] && !sda_q && sda_f[p];
			assign rise    = !scl_q && scl_f[p];
			assign fall    = scl_q && !scl_f[p];

			always_ff @(posedge link_clk_i or negedge link_rstn)
			begin
				if (!link_rstn)
				begin
					scl_q <= 1'b1;
					sda_q <= 1'b1;
				end
				else
				begin
					scl_q <= scl_f[p];
					sda_q <= sda_f[p];
				end
			end

			// START events cross to the core as a toggle.
			always_ff @(posedge link_clk_i or negedge link_rstn)
			begin
				if (!link_rstn)
				begin
					tg <= 1'b0;
				end
				else if (start_c)
				begin
					tg <= ~tg;
				end
			end

			always_ff @(posedge link_clk_i or negedge link_rstn)
			begin
				if (!link_rstn)
				begin
					st  <= SLV_IDLE;
					sh  <= 8'h00;
					cnt <= 4'h0;
					drv <= 1'b0;
					wr  <= 1'b0;
				end
				else if (start_c)
				begin
					st  <= SLV_ADDR;
					cnt <= 4'h0;
					drv <= 1'b0;
					wr  <= 1'b0;
				end
				else if (stop_c)
				begin
					st  <= SLV_IDLE;
					drv <= 1'b0;
					wr  <= 1'b0;
				end
				else
				begin
					wr <= 1'b0;
					unique case (st)
						SLV_IDLE:
						begin
							drv <= 1'b0;
						end
						SLV_ADDR, SLV_DUMMY, SLV_WDATA:
						begin
							if (rise && cnt < BYTE_BITS)
							begin
								sh  <= {sh[6:0], sda_f[p]};
								cnt <= cnt + 4'h1;
							end
							else if (fall && cnt == BYTE_BITS)
							begin
								if (st == SLV_ADDR && sh == CFG_ADDR_WR) // R11
								begin
									drv <= 1'b1; // R13
									st  <= SLV_ACK_ADDR;
								end
								else if (st == SLV_ADDR && sh == CFG_ADDR_RD) // R11
								begin
									drv <= 1'b1; // R12
									st  <= SLV_ACK_READ;
								end
								else if (st == SLV_ADDR)
								begin
									st <= SLV_IDLE;
								end
								else if (st == SLV_DUMMY)
								begin
									drv <= 1'b1; // R13
									st  <= SLV_ACK_DUMMY;
								end
								else
								begin
									drv <= 1'b1; // R13
									wr  <= 1'b1;
									st  <= SLV_ACK_WDATA;
								end
							end
						end
						SLV_ACK_ADDR, SLV_ACK_DUMMY, SLV_ACK_WDATA:
						begin
							if (fall)
							begin
								drv <= 1'b0;
								cnt <= 4'h0;
								if (st == SLV_ACK_ADDR)
								begin
									st <= SLV_DUMMY;
								end
								else if (st == SLV_ACK_DUMMY)
								begin
									st <= SLV_WDATA;
								end
								else
								begin
									st <= SLV_IDLE;
								end
							end
						end
						SLV_ACK_READ:
						begin
							if (fall)
							begin
								drv <= ~cfg[7]; // R12
								sh  <= {cfg[6:0], 1'b0};
								cnt <= 4'h1;
								st  <= SLV_RDATA;
							end
						end
						SLV_RDATA:
						begin
							if (fall && cnt < BYTE_BITS)
							begin
								drv <= ~sh[7]; // R12
								sh  <= {sh[6:0], 1'b0};
								cnt <= cnt + 4'h1;
							end
							else if (fall)
							begin
								drv <= 1'b0;
								st  <= SLV_RACK;
							end
						end
						SLV_RACK:
						begin
							if (rise)
							begin
								st <= SLV_IDLE; // R12
							end
						end
						default:
						begin
							st  <= SLV_IDLE;
							drv <= 1'b0;
						end
					endcase
				end
			end

			assign sda_drv[p]  = drv;
			assign start_tg[p] = tg;
			assign cfg_wr[p]   = wr;
			assign cfg_wd[p]   = sh;
		end
	endgenerate

	// Data line enables leave straight from a flip-flop.
	always_ff @(posedge link_clk_i or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			monitor_port_data_oe_n_o <= 1'b1;
			display_port_data_oe_n_o <= 1'b1;
		end
		else
		begin
			monitor_port_data_oe_n_o <= ~sda_drv[PORT_MON]; // R12
			display_port_data_oe_n_o <= ~sda_drv[PORT_DSP]; // R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration register and its decode (link domain).

	always_ff @(posedge link_clk_i)
	begin
		if (cfg_wr[PORT_DSP])
		begin
			cfg <= cfg_wd[PORT_DSP]; // R10
		end
		else if (cfg_wr[PORT_MON])
		begin
			cfg <= cfg_wd[PORT_MON]; // R4
		end
	end

	always_ff @(posedge link_clk_i or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			upper_bank_active_o    <= 1'b0;
			single_bank_o          <= 1'b0;
			monitor_write_permit_o <= 1'b0;
			display_write_permit_o <= 1'b1;
		end
		else
		begin
			single_bank_o <= cfg[CFG_SINGLE_BIT]; // R4
			if (cfg[CFG_SINGLE_BIT])
			begin
				upper_bank_active_o <= 1'b0; // R5
			end
			else if (!cfg[CFG_PICK_HI_BIT])
			begin
				upper_bank_active_o <= bank_pin_f; // R6
			end
			else
			begin
				upper_bank_active_o <= cfg[CFG_PICK_LO_BIT]; // R7
			end
			monitor_write_permit_o <= cfg[CFG_WE_BIT]; // R8
			display_write_permit_o <= 1'b1; // R9
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossings into the core domain.

	logic [PORT_CNT-1:0]  tg_s1;
	logic [PORT_CNT-1:0]  tg_s2;
	logic [PORT_CNT-1:0]  tg_s3;
	logic [PORT_CNT-1:0]  hi_s1;
	logic [PORT_CNT-1:0]  hi_s2;
	logic [PORT_CNT-1:0]  hi_s3;
	logic [PORT_CNT-1:0]  scl_high;
	logic [PORT_CNT-1:0]  start_ev;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tg_s1    <= '0;
			tg_s2    <= '0;
			tg_s3    <= '0;
			hi_s1    <= '1;
			hi_s2    <= '1;
			hi_s3    <= '1;
			scl_high <= '1;
		end
		else
		begin
			tg_s1    <= start_tg;
			tg_s2    <= tg_s1;
			tg_s3    <= tg_s2;
			hi_s1    <= scl_f;
			hi_s2    <= hi_s1;
			hi_s3    <= hi_s2;
			// A clock level counts once stages two and three agree.
			scl_high <= (hi_s2 & hi_s3) | (scl_high & (hi_s2 | hi_s3));
		end
	end

	assign start_ev = tg_s2 ^ tg_s3;

	////////////////////////////////////////////////////////////////////////
	// Arbiter and one-second release timer (core domain).

	dpiac_arb_st_t   arb;
	logic [TMR_W-1:0] tmr;
	logic             own_high;
	logic             tmr_done;

	assign own_high = (arb == ARB_MON_OWNS) ? scl_high[PORT_MON]
	                                        : scl_high[PORT_DSP];
	assign tmr_done = own_high &&
	                  (tmr == TMR_W'(RELEASE_CYCLES - 1));

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			arb <= ARB_IDLE;
		end
		else
		begin
			unique case (arb)
				ARB_IDLE:
				begin
					if (start_ev[PORT_MON])
					begin
						arb <= ARB_MON_OWNS; // R2
					end
					else if (start_ev[PORT_DSP])
					begin
						arb <= ARB_DSP_OWNS; // R2
					end
				end
				ARB_MON_OWNS, ARB_DSP_OWNS:
				begin
					if (tmr_done)
					begin
						arb <= ARB_IDLE; // R3
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tmr <= '0;
		end
		else if (arb == ARB_IDLE || !own_high || tmr_done)
		begin
			tmr <= '0; // R14
		end
		else
		begin
			tmr <= tmr + TMR_W'(1); // R14
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			monitor_port_clock_oe_n_o <= 1'b1;
			display_port_clock_oe_n_o <= 1'b1;
			arb_busy_o                <= 1'b0;
		end
		else
		begin
			// Released while idle; the non-owner is held low.
			monitor_port_clock_oe_n_o <= (arb != ARB_DSP_OWNS); // R1
			display_port_clock_oe_n_o <= (arb != ARB_MON_OWNS); // R1
			arb_busy_o                <= (arb != ARB_IDLE);
		end
	end

endmodule // dpiac_arbiter_config

// ### design/dpiac_pkg.sv
/*
 * Shared constants and types for the two-port arbiter and configuration
 * block: bus addresses, register field positions, erased value, timing.
 * Assumes a 250 MHz core clock and a separate link sampling clock.
 */
package dpiac_pkg;

	// Bus address bytes of the configuration register.
	localparam logic [7:0]  CFG_ADDR_WR  = 8'h62;
	localparam logic [7:0]  CFG_ADDR_RD  = 8'h63;

	// Field positions of bank_and_write_config.
	localparam int unsigned CFG_WE_BIT   = 3;
	localparam int unsigned CFG_PICK_HI_BIT = 2;
	localparam int unsigned CFG_PICK_LO_BIT = 1;
	localparam int unsigned CFG_SINGLE_BIT  = 0;

	// Value held by an erased, never written register.
	localparam logic [7:0]  CFG_ERASED   = 8'hFF;

	// Port indices.
	localparam int unsigned PORT_MON     = 0;
	localparam int unsigned PORT_DSP     = 1;
	localparam int unsigned PORT_CNT     = 2;

	// Bits in one bus byte.
	localparam logic [3:0]  BYTE_BITS    = 4'h8;

	// Idle time after which the initiating port counts as finished.
	localparam longint unsigned RELEASE_TIME_NS = 64'd1000000000;
	localparam longint unsigned CORE_CLK_NS     = 64'd4;
	localparam int unsigned RELEASE_CYC =
		int'(RELEASE_TIME_NS / CORE_CLK_NS);
	localparam int unsigned TMR_W        = 28;

	// Per-port bus slave states.
	typedef enum logic [3:0] {
		SLV_IDLE,
		SLV_ADDR,
		SLV_ACK_ADDR,
		SLV_DUMMY,
		SLV_ACK_DUMMY,
		SLV_WDATA,
		SLV_ACK_WDATA,
		SLV_ACK_READ,
		SLV_RDATA,
		SLV_RACK
	} dpiac_slv_st_t;

	// Arbiter ownership states.
	typedef enum logic [1:0] {
		ARB_IDLE,
		ARB_MON_OWNS,
		ARB_DSP_OWNS
	} dpiac_arb_st_t;

endpackage

// ### design/dpiac_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_i; the output only
 * changes once the second and third stages agree.
 */
`timescale 1ns/100ps

module dpiac_sync
#(
	parameter logic INIT = 1'b1
)
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic d_i,
	output logic      q_o
);

	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s1  <= INIT;
			s2  <= INIT;
			s3  <= INIT;
			q_o <= INIT;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
			begin
				q_o <= s3;
			end
		end
	end

endmodule // dpiac_sync

// ### verification/dpiac_arbiter_config_chk.sv
/* Port checker for the two-port arbiter, bound into the design.
   Assumes pins resolved outside; all checks on the core clock. */
`timescale 1ns/100ps

module dpiac_arbiter_config_chk
#(
	parameter int unsigned RELEASE_CYCLES = 200
)
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic monitor_port_clock_i,
	input wire logic display_port_clock_i,
	input wire logic monitor_port_clock_oe_n_o,
	input wire logic display_port_clock_oe_n_o,
	input wire logic upper_bank_active_o,
	input wire logic single_bank_o,
	input wire logic display_write_permit_o,
	input wire logic arb_busy_o
);
	localparam int unsigned LIM = RELEASE_CYCLES + 64;
	logic [31:0] oc;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	////////////////////////////////
	// Counts cycles the owning port's clock stays high.
	always_ff @(posedge core_clk_i or negedge rstn_i)
		if (!rstn_i)
			oc <= '0;
		else if (arb_busy_o && (display_port_clock_oe_n_o ?
			display_port_clock_i : monitor_port_clock_i))
			oc <= oc + 32'(oc < LIM);
		else
			oc <= '0;
	////////////////////////////////
	property p_idle;
		!arb_busy_o |-> monitor_port_clock_oe_n_o && display_port_clock_oe_n_o;
	endproperty
	a_idle: assert property (p_idle) else $error("clock held while idle");
	property p_one;
		arb_busy_o |-> monitor_port_clock_oe_n_o != display_port_clock_oe_n_o;
	endproperty
	a_one: assert property (p_one) else $error("not one port held");
	property p_entry;
		$rose(arb_busy_o) |->
			$fell(monitor_port_clock_oe_n_o) || $fell(display_port_clock_oe_n_o);
	endproperty
	a_entry: assert property (p_entry) else $error("busy without hold");
	// A short high stretch of the owner's clock must not end the hold.
	property p_low;
		arb_busy_o && oc == 32'h0 && $past(oc) != 32'h0 &&
			$past(oc) < RELEASE_CYCLES - 16 |=> arb_busy_o [*8];
	endproperty
	a_low: assert property (p_low) else $error("released after low");
	property p_rel;
		arb_busy_o |-> oc < LIM;
	endproperty
	a_rel: assert property (p_rel) else $error("hold not released");
	property p_min;
		$fell(arb_busy_o) |-> oc >= RELEASE_CYCLES - 4;
	endproperty
	a_min: assert property (p_min) else $error("released too early");
	property p_dsp;
		display_write_permit_o;
	endproperty
	a_dsp: assert property (p_dsp) else $error("display write blocked");
	property p_single;
		single_bank_o |-> !upper_bank_active_o;
	endproperty
	a_single: assert property (p_single) else $error("upper in one bank");
endmodule // dpiac_arbiter_config_chk

bind dpiac_arbiter_config dpiac_arbiter_config_chk
	#(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.monitor_port_clock_i(monitor_port_clock_i),
	.display_port_clock_i(display_port_clock_i),
	.monitor_port_clock_oe_n_o(monitor_port_clock_oe_n_o),
	.display_port_clock_oe_n_o(display_port_clock_oe_n_o),
	.upper_bank_active_o(upper_bank_active_o),
	.single_bank_o(single_bank_o),
	.display_write_permit_o(display_write_permit_o),
	.arb_busy_o(arb_busy_o));

// ### verification/dpiac_master.sv
/* Model of the two bus masters, one per port, sharing one task set.
   Assumes open-drain wires with pull-ups resolved by the bench. */
`timescale 1ns/100ps

module dpiac_master
(
	input  wire logic       clk_i,
	input  wire logic [1:0] scl_i,
	input  wire logic [1:0] sda_i,
	output logic      [1:0] scl_o,
	output logic      [1:0] sda_o
);
	initial
	begin
		scl_o = 2'h3;
		sda_o = 2'h3;
	end
	task automatic half();
		repeat (90) @(negedge clk_i);
	endtask
	task automatic start(input int p);
		half();
		sda_o[p] = 1'b0;
		half();
		scl_o[p] = 1'b0;
	endtask
	task automatic xfer(input int p, input logic [8:0] d,
		output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			half();
			sda_o[p] = d[i];
			half();
			scl_o[p] = 1'b1;
			wait (scl_i[p]);
			half();
			q[i] = sda_i[p];
			scl_o[p] = 1'b0;
		end
	endtask
	task automatic stop(input int p);
		half();
		sda_o[p] = 1'b0;
		half();
		scl_o[p] = 1'b1;
		half();
		sda_o[p] = 1'b1;
	endtask
endmodule // dpiac_master

// ### verification/dual_port_i2c_arbiter_config_tb.sv
/* Bench driving both ports through the master model.
   Assumes open-drain wires pulled up here; short release count. */
`timescale 1ns/100ps

module dual_port_i2c_arbiter_config_tb import dpiac_pkg::*;;
	logic       core_clk_i;
	logic       link_clk_i;
	logic       rstn_i;
	logic       pin;
	wire  [1:0] m_scl;
	wire  [1:0] m_sda;
	wire  [1:0] c_oe_n;
	wire  [1:0] d_oe_n;
	wire        upper;
	wire        single;
	wire        mon_wp;
	wire        dsp_wp;
	wire        busy;
	wire  [1:0] scl = m_scl & c_oe_n;
	wire  [1:0] sda = m_sda & d_oe_n;
	int         num_errors = 0;
	int         n_compared = 0;
	logic [7:0] tv [5] = '{8'h00, 8'h02, 8'h04, 8'h0E, 8'hF7};
	logic [7:0] r;

	dpiac_arbiter_config #(.RELEASE_CYCLES(200)) dut (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
		.monitor_port_clock_i(scl[0]), .monitor_port_data_i(sda[0]),
		.display_port_clock_i(scl[1]), .display_port_data_i(sda[1]),
		.bank_select_pin_i(pin), .upper_bank_active_o(upper),
		.monitor_port_clock_oe_n_o(c_oe_n[0]),
		.display_port_clock_oe_n_o(c_oe_n[1]),
		.monitor_port_data_oe_n_o(d_oe_n[0]),
		.display_port_data_oe_n_o(d_oe_n[1]),
		.single_bank_o(single), .monitor_write_permit_o(mon_wp),
		.display_write_permit_o(dsp_wp), .arb_busy_o(busy));
	dpiac_master m (.clk_i(core_clk_i), .scl_i(scl), .sda_i(sda),
		.scl_o(m_scl), .sda_o(m_sda));

	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		link_clk_i = 1'b0;
		#7;
		forever #16 link_clk_i = ~link_clk_i;
	end
	////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic do_reset();
		rstn_i = 1'b0;
		repeat (5) @(negedge link_clk_i);
		@(negedge core_clk_i);
		rstn_i = 1'b1;
		repeat (80) @(negedge core_clk_i);
	endtask
	task automatic op(input int p, input logic [7:0] a, input logic [7:0] v,
		output logic [7:0] rd);
		logic [8:0] q;
		int         n;
		m.start(p);
		chk("held", 8'h00, 8'(c_oe_n[1 - p]));
		chk("owner free", 8'h01, 8'(c_oe_n[p]));
		m.xfer(p, {a, 1'b1}, q);
		chk("addr ack", 8'(a[7:1] != 7'h31), 8'(q[0]));
		if (a == CFG_ADDR_WR)
		begin
			m.xfer(p, 9'h001, q);
			chk("dummy ack", 8'h00, 8'(q[0]));
			m.xfer(p, {v, 1'b1}, q);
			chk("data ack", 8'h00, 8'(q[0]));
		end
		if (a == CFG_ADDR_RD)
		begin
			m.xfer(p, 9'h1FF, q);
			rd = q[8:1];
		end
		m.stop(p);
		chk("busy", 8'h01, 8'(busy));
		n = 0;
		while (busy && n < 1000)
		begin
			@(negedge core_clk_i);
			n++;
		end
		chk("release", 8'h01, 8'(n >= 105 && n <= 180));
	endtask
	////////////////////////////////
	initial
	begin
		pin = 1'b0;
		do_reset();
		chk("idle", 8'h03, 8'(c_oe_n));
		op(0, CFG_ADDR_RD, 8'h00, r);
		chk("erased", CFG_ERASED, r);
		op(1, 8'hA0, 8'h00, r);
		for (int i = 0; i < 5; i++)
		begin
			op(i % 2, CFG_ADDR_WR, tv[i], r);
			for (int b = 0; b < 2; b++)
			begin
				pin = b[0];
				repeat (60) @(negedge core_clk_i);
				chk("bank", 8'(!tv[i][0] && (tv[i][2] ? tv[i][1] : b[0])),
					8'(upper));
				chk("single", 8'(tv[i][0]), 8'(single));
				chk("mon wp", 8'(tv[i][3]), 8'(mon_wp));
				chk("dsp wp", 8'h01, 8'(dsp_wp));
			end
			op(1 - i % 2, CFG_ADDR_RD, 8'h00, r);
			chk("readback", tv[i], r);
		end
		do_reset();
		op(1, CFG_ADDR_RD, 8'h00, r);
		chk("kept", 8'hF7, r);
		stop_test();
	end
	initial
	begin
		repeat (95000) @(posedge core_clk_i);
		num_errors++;
		stop_test();
	end
endmodule // dual_port_i2c_arbiter_config_tb
